// [tiem_top.sv]
// Timer interrupt enable masks with an AHB-Lite register slave.
//
// Summary of operation
// R1: Channel-0 capture enables pass or block flags.
// R2: Channel-0 bit 0 gates capture flag A.
// R3: Channel-1 bit 6 gates overflow request.
// R4: Channel-1 bits 5..0 gate match F..A.
// R5: Channel-2 bit 2 gates overflow request.
// R6: Channel-2 bits 1..0 gate match B, A.
// R7: Channel-3 bit 4 gates overflow request.
// R8: Channel-3 bits 3..0 gate match D..A.
// R9: Shared bit 7 gates channel-4 overflow.
// R10: Shared bits 6..3 gate channel-4 matches.
// R11: Shared bit 2 gates channel-5 overflow.
// R12: Shared bits 1..0 gate channel-5 matches.
// R13: Cycle enables for channels 6..9 at 6,4,2,0.
// R14: Cycle bit 6 gates channel-6 flag.
// R15: All enables start at zero.
// R16: Single reserved bits read zero.
// R17: Reserved bit ranges read zero.
// R18: Request only when flag and enable set.
// R19: Reset or standby clears all enables.
// R20: Channels 7..9 cycle enables pass flags.
// R21: Request is flag AND enable, drops promptly.
`timescale 1ns/1ns

module tiem_top
   import tiem_pkg::*;
(
   input  wire logic        hclk,      // System clock.
   input  wire logic        hresetn,   // Reset, low.
   input  wire logic        standby,   // Standby entry.
   input  wire logic        hsel,      // Slave select.
   input  wire logic [31:0] haddr,     // Address.
   input  wire logic [1:0]  htrans,    // Transfer type.
   input  wire logic        hwrite,    // Write.
   input  wire logic [2:0]  hsize,     // Size.
   input  wire logic [31:0] hwdata,    // Write data.
   input  wire logic        hready,    // Bus ready.
   output logic      [31:0] hrdata,    // Read data.
   output logic             hreadyout, // Slave ready.
   output logic             hresp,     // Response.
   input  wire tiem_vec_t   flags,     // Status flags.
   output tiem_vec_t        irq_req    // Gated requests.
);

   // Writable-bit masks indexed by register.
   localparam logic [7:0] WMASK [TIEM_NREG] = '{
      TIEM_MASK_CH0,
      TIEM_MASK_CH1,
      TIEM_MASK_CH2,
      TIEM_MASK_CH3,
      TIEM_MASK_CH45,
      TIEM_MASK_CYC
   };

   // Word index of an address inside the block.
   function automatic logic [2:0] tiem_ix(
      input logic [31:0] a
   );
      tiem_ix = a[TIEM_IX_MSB:TIEM_IX_LSB];
   endfunction

   // An address hits a word only when aligned and in range.
   function automatic logic tiem_hit(
      input logic [31:0] a
   );
      tiem_hit = (a[31:TIEM_IX_MSB+1] == '0)
         && (a[TIEM_IX_LSB-1:0] == '0);
   endfunction

   // State of the bus slave.
   logic [7:0]  en_r   [TIEM_NREG];
   logic [7:0]  en_nxt [TIEM_NREG];
   logic        wr_pend_r;
   logic        wr_ok_r;
   logic [2:0]  wr_ix_r;
   logic        rd_pend_r;
   logic        rd_ok_r;
   logic [2:0]  rd_ix_r;
   logic [31:0] hrdata_r;
   logic        hreadyout_r;
   tiem_vec_t   req_r;

   // Address phase decode.
   wire acc    = hsel & hready
      & (htrans == TIEM_HTRANS_NONSEQ);
   wire wr_acc = acc & hwrite;
   wire rd_acc = acc & ~hwrite;

   // Word writes and low-lane narrow writes are taken; the rest
   // are ignored with an OKAY answer.
   wire size_ok = (hsize <= TIEM_HSIZE_WORD);
   wire a_hit   = tiem_hit(haddr) & size_ok;
   wire [2:0] a_ix = tiem_ix(haddr);

   // Address phase capture.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_ok_r   <= 1'b0;
         wr_ix_r   <= 3'h0;
      end else if (hready) begin
         wr_pend_r <= wr_acc;
         wr_ok_r   <= a_hit;
         wr_ix_r   <= a_ix;
      end
   end

   // A read holds hready low for one cycle so that hrdata comes
   // straight from a flop and sees any write just before it.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_pend_r <= 1'b0;
         rd_ok_r   <= 1'b0;
         rd_ix_r   <= 3'h0;
      end else begin
         rd_pend_r <= rd_acc;
         rd_ok_r   <= rd_acc ? a_hit : rd_ok_r;
         rd_ix_r   <= rd_acc ? a_ix : rd_ix_r;
      end
   end

   // Ready drops in the cycle after a read is taken.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout_r <= 1'b1;
      end else begin
         hreadyout_r <= ~rd_acc;
      end
   end

   // Write strobe for each register in the data phase.
   wire wr_go = wr_pend_r & wr_ok_r;

   // Enable registers; reserved bits never store a one, so they
   // read as zero whatever software writes to them.
   genvar gi;
   generate
      for (gi = 0; gi < TIEM_NREG; gi++) begin : g_en
         wire sel = wr_go
            && (wr_ix_r == 3'(gi));
         assign en_nxt[gi] =
            standby ? TIEM_EN_RST :          // [R19]
            sel ? (hwdata[7:0] & WMASK[gi])  // [R16] [R17]
                : en_r[gi];
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               en_r[gi] <= TIEM_EN_RST;      // [R15] [R19]
            end else begin
               en_r[gi] <= en_nxt[gi];
            end
         end
      end
   endgenerate

   // Enables gathered in the layout of the flag groups.
   tiem_vec_t en_vec;
   assign en_vec = {
      en_r[5],   // [R13] [R14] [R20]
      en_r[4],   // [R9] [R10] [R11] [R12]
      en_r[3],   // [R7] [R8]
      en_r[2],   // [R5] [R6]
      en_r[1],   // [R3] [R4]
      en_r[0]    // [R1] [R2]
   };

   // Every request is its flag ANDed with its enable, so it
   // falls one cycle after either one goes low.
   wire tiem_vec_t req_nxt = flags & en_vec; // [R18] [R21]

   // Requests, all groups in one flop stage.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req_r <= '0;
      end else begin
         req_r <= req_nxt; // [R1] [R3] [R5] [R7] [R9] [R11] [R13]
      end
   end

   // Read words: six enable registers, then two request words.
   logic [31:0] rd_word [8];
   generate
      for (gi = 0; gi < TIEM_NREG; gi++) begin : g_rd
         assign rd_word[gi] = {24'h000000, en_r[gi]};
      end
   endgenerate
   assign rd_word[6] = req_r[31:0];
   assign rd_word[7] = {16'h0000, req_r[47:32]};

   // Unmapped reads return zero.
   wire [31:0] rd_val = rd_ok_r
      ? rd_word[rd_ix_r] : 32'h00000000;

   // Read data flop, loaded in the wait cycle.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_r <= 32'h00000000;
      end else if (rd_pend_r) begin
         hrdata_r <= rd_val;
      end
   end

   // Outputs straight from flops; hresp is tied low.
   assign hrdata    = hrdata_r;
   assign hreadyout = hreadyout_r;
   assign hresp     = 1'b0;
   assign irq_req   = req_r;

   // Checks of the gating and the register file.
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Read of a given word.
   sequence s_rd(logic [4:0] ofs);
      rd_acc && a_hit && (haddr[4:0] == ofs);
   endsequence

   // The wait cycle and the answer cycle of a read.
   sequence s_rd_ans;
      !hreadyout ##1 hreadyout;
   endsequence

   property p_ch0_a_block;
      !en_r[0][0] |=> !irq_req.ch0[0];
   endproperty
   a_ch0_a_block: assert property (p_ch0_a_block) // [R2]
      else $error("ch0 A request without enable");

   property p_ch0_pass;
      (flags.ch0[2:0] & en_r[0][2:0]) != 3'h0
         |=> irq_req.ch0[2:0] != 3'h0;
   endproperty
   a_ch0_pass: assert property (p_ch0_pass) // [R1]
      else $error("ch0 capture request missing");

   property p_ch1;
      flags.ch1[TIEM_B_CH1_WRAP]
         && en_r[1][TIEM_B_CH1_WRAP]
         |=> irq_req.ch1[TIEM_B_CH1_WRAP]
         && (irq_req.ch1[5:0]
            == $past(flags.ch1[5:0] & en_r[1][5:0]));
   endproperty
   a_ch1: assert property (p_ch1) // [R3] [R4]
      else $error("ch1 request wrong");

   property p_ch2_ch3;
      ##1 (irq_req.ch2[TIEM_B_CH2_WRAP:0]
         == $past(flags.ch2[2:0] & en_r[2][2:0]))
      && (irq_req.ch3[TIEM_B_CH3_WRAP:0]
         == $past(flags.ch3[4:0] & en_r[3][4:0]));
   endproperty
   a_ch2_ch3: assert property (p_ch2_ch3) // [R5] [R6] [R7] [R8]
      else $error("ch2 or ch3 request wrong");

   property p_ch45;
      flags.ch45[TIEM_B_CH4_WRAP]
         && en_r[4][TIEM_B_CH4_WRAP]
         && !flags.ch45[TIEM_B_CH5_WRAP]
         |=> irq_req.ch45[TIEM_B_CH4_WRAP]
         && !irq_req.ch45[TIEM_B_CH5_WRAP];
   endproperty
   a_ch45: assert property (p_ch45) // [R9] [R10] [R11] [R12]
      else $error("ch4/5 request wrong");

   property p_cyc;
      ##1 irq_req.cyc
         == $past(flags.cyc & en_r[5] & TIEM_MASK_CYC);
   endproperty
   a_cyc: assert property (p_cyc) // [R13] [R14] [R20]
      else $error("cycle request wrong");

   property p_no_flag;
      flags == '0 |=> irq_req == '0;
   endproperty
   a_no_flag: assert property (p_no_flag) // [R18]
      else $error("request without flag");

   property p_drop;
      irq_req.ch0[0] && !en_r[0][0] |=> !irq_req.ch0[0];
   endproperty
   a_drop: assert property (p_drop) // [R21]
      else $error("request held after disable");

   property p_standby;
      standby |=> (en_r[0] == TIEM_EN_RST)
         && (en_r[4] == TIEM_EN_RST)
         ##1 irq_req == '0;
   endproperty
   a_standby: assert property (p_standby) // [R19] [R15]
      else $error("standby left enables set");

   property p_rsv_bits;
      !en_r[1][7] && ((en_r[5] & ~TIEM_MASK_CYC) == 8'h00);
   endproperty
   a_rsv_bits: assert property (p_rsv_bits) // [R16]
      else $error("reserved enable bit set");

   property p_rsv_read;
      s_rd(TIEM_OFS_CH2) |=> s_rd_ans ##0 (hrdata[31:3] == '0);
   endproperty
   a_rsv_read: assert property (p_rsv_read) // [R17]
      else $error("reserved ch2 bits read nonzero");

   property p_wr_read;
      wr_go && (wr_ix_r == 3'h3) ##1 s_rd(TIEM_OFS_CH3)
         |=> s_rd_ans ##0 (hrdata[7:0]
            == ($past(hwdata[7:0], 3) & TIEM_MASK_CH3)
            || $past(standby, 3));
   endproperty
   a_wr_read: assert property (p_wr_read) // [R17]
      else $error("ch3 read back wrong");

   // Channel-6 cycle request stays low while its enable is clear.
   property p_ch6_block;
      !en_r[5][TIEM_B_CH6_CYC] |=> !irq_req.cyc[TIEM_B_CH6_CYC];
   endproperty
   a_ch6_block: assert property (p_ch6_block) // [R14]
      else $error("ch6 cycle request without enable");

   // Channels 7 to 9 still raise requests while channel 6 is idle.
   property p_cyc_789;
      !flags.cyc[TIEM_B_CH6_CYC]
         && ((flags.cyc & en_r[5]) != 8'h00)
         |=> irq_req.cyc != 8'h00;
   endproperty
   a_cyc_789: assert property (p_cyc_789) // [R20]
      else $error("ch7 to ch9 cycle request missing");

   // Channel-5 requests follow flag AND enable bit for bit.
   property p_ch5;
      ##1 irq_req.ch45[TIEM_B_CH5_WRAP:0]
         == $past(flags.ch45[TIEM_B_CH5_WRAP:0] & en_r[4][TIEM_B_CH5_WRAP:0]);
   endproperty
   a_ch5: assert property (p_ch5) // [R11] [R12]
      else $error("ch5 request wrong");

   // Channel-4 match requests sit between the two wrap bits.
   property p_ch4_match;
      ##1 irq_req.ch45[TIEM_B_CH4_WRAP-1:TIEM_B_CH5_WRAP+1]
         == $past(flags.ch45[TIEM_B_CH4_WRAP-1:TIEM_B_CH5_WRAP+1]
            & en_r[4][TIEM_B_CH4_WRAP-1:TIEM_B_CH5_WRAP+1]);
   endproperty
   a_ch4_match: assert property (p_ch4_match) // [R10]
      else $error("ch4 match request wrong");

   // A request falls one cycle after its flag is cleared, even
   // with the enable still set.
   property p_flag_drop;
      irq_req.ch1[TIEM_B_CH1_WRAP] && !flags.ch1[TIEM_B_CH1_WRAP]
         |=> !irq_req.ch1[TIEM_B_CH1_WRAP];
   endproperty
   a_flag_drop: assert property (p_flag_drop) // [R21]
      else $error("request held after flag cleared");

   // Standby also clears the registers that a_standby leaves out.
   property p_standby_all;
      standby |=> (en_r[1] == TIEM_EN_RST)
         && (en_r[2] == TIEM_EN_RST)
         && (en_r[3] == TIEM_EN_RST)
         && (en_r[5] == TIEM_EN_RST);
   endproperty
   a_standby_all: assert property (p_standby_all) // [R19]
      else $error("standby left an enable set");

   // A data-phase write lands with its reserved bit dropped,
   // unless standby wins in the same cycle.
   property p_wr_land;
      wr_go && (wr_ix_r == 3'h1) && !standby
         |=> en_r[1] == ($past(hwdata[7:0]) & TIEM_MASK_CH1);
   endproperty
   a_wr_land: assert property (p_wr_land) // [R16]
      else $error("ch1 write did not land masked");

   // Reserved ranges of channels 2 and 3 never hold a one.
   property p_rsv_rng;
      ((en_r[2] & ~TIEM_MASK_CH2) == 8'h00)
         && ((en_r[3] & ~TIEM_MASK_CH3) == 8'h00);
   endproperty
   a_rsv_rng: assert property (p_rsv_rng) // [R17]
      else $error("reserved enable range set");

endmodule // tiem_top

// [tiem_pkg.sv]
// Constants and types of the timer interrupt enable mask block.
package tiem_pkg;

   // Number of enable registers.
   localparam int TIEM_NREG = 6;

   // Word index field of the byte address.
   localparam int TIEM_IX_LSB = 2;
   localparam int TIEM_IX_MSB = 4;

   // Byte offsets of the registers.
   localparam logic [4:0] TIEM_OFS_CH0   = 5'h00;
   localparam logic [4:0] TIEM_OFS_CH1   = 5'h04;
   localparam logic [4:0] TIEM_OFS_CH2   = 5'h08;
   localparam logic [4:0] TIEM_OFS_CH3   = 5'h0C;
   localparam logic [4:0] TIEM_OFS_CH45  = 5'h10;
   localparam logic [4:0] TIEM_OFS_CYC   = 5'h14;
   localparam logic [4:0] TIEM_OFS_REQLO = 5'h18;
   localparam logic [4:0] TIEM_OFS_REQHI = 5'h1C;

   // Reset value of every enable register.
   localparam logic [7:0] TIEM_EN_RST = 8'h00;

   // Writable bits of each enable register.
   localparam logic [7:0] TIEM_MASK_CH0  = 8'h1F;
   localparam logic [7:0] TIEM_MASK_CH1  = 8'h7F;
   localparam logic [7:0] TIEM_MASK_CH2  = 8'h07;
   localparam logic [7:0] TIEM_MASK_CH3  = 8'h1F;
   localparam logic [7:0] TIEM_MASK_CH45 = 8'hFF;
   localparam logic [7:0] TIEM_MASK_CYC  = 8'h55;

   // Bit positions used by name.
   localparam int TIEM_B_CH1_WRAP = 6;
   localparam int TIEM_B_CH2_WRAP = 2;
   localparam int TIEM_B_CH3_WRAP = 4;
   localparam int TIEM_B_CH4_WRAP = 7;
   localparam int TIEM_B_CH5_WRAP = 2;
   localparam int TIEM_B_CH6_CYC  = 6;

   // Bus encodings.
   localparam logic [1:0] TIEM_HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] TIEM_HSIZE_WORD    = 3'h2;

   // Flags in and requests out, each group in its register's bit layout.
   typedef struct packed {
      logic [7:0] cyc;
      logic [7:0] ch45;
      logic [7:0] ch3;
      logic [7:0] ch2;
      logic [7:0] ch1;
      logic [7:0] ch0;
   } tiem_vec_t;

endpackage

// [tiem_intc_model.sv]
// Behavioural interrupt controller that latches the gated timer requests.
`timescale 1ns/1ns

module tiem_intc_model
   import tiem_pkg::*;
(
   input  wire logic      hclk,    // System clock.
   input  wire logic      hresetn, // Reset, low.
   input  wire tiem_vec_t irq_req, // Gated requests.
   input  wire logic      clr,     // Forget latched requests.
   output tiem_vec_t      seen_r   // Requests seen since the last clear.
);
   // Requests are levels; latching them means a short one is never lost between polls.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) seen_r <= '0;
      else if (clr) seen_r <= '0;
      else seen_r <= seen_r | irq_req;
   end
endmodule // tiem_intc_model

// [tiem_top_test.sv]
// Self-checking testbench for the timer interrupt enable masks.
`timescale 1ns/1ns

module tiem_top_test;
   import tiem_pkg::*;
   typedef struct packed {logic [4:0] ofs; logic [7:0] wr; logic [7:0] rd;} tiem_row_t;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        standby = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic        clr = 1'b0;
   logic [31:0] haddr = '0;
   logic [31:0] hwdata = '0;
   logic [31:0] q;
   logic        resp_q;
   logic [1:0]  htrans = '0;
   logic [2:0]  hsize = TIEM_HSIZE_WORD;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   wire         hready = hreadyout;
   tiem_vec_t   flags = '0;
   tiem_vec_t   irq_req;
   tiem_vec_t   seen;
   int          bad_count = 0;
   int          n_compared = 0;
   // Written value and the value that should read back, three passes over all registers.
   tiem_row_t   rows [18] = '{
      '{5'h00, 8'hFF, 8'h1F}, '{5'h04, 8'hFF, 8'h7F}, '{5'h08, 8'hFF, 8'h07},
      '{5'h0C, 8'hFF, 8'h1F}, '{5'h10, 8'hFF, 8'hFF}, '{5'h14, 8'hFF, 8'h55},
      '{5'h00, 8'hA5, 8'h05}, '{5'h04, 8'hA5, 8'h25}, '{5'h08, 8'hA5, 8'h05},
      '{5'h0C, 8'hA5, 8'h05}, '{5'h10, 8'hA5, 8'hA5}, '{5'h14, 8'hA5, 8'h05},
      '{5'h00, 8'h5A, 8'h1A}, '{5'h04, 8'h5A, 8'h5A}, '{5'h08, 8'h5A, 8'h02},
      '{5'h0C, 8'h5A, 8'h1A}, '{5'h10, 8'h5A, 8'h5A}, '{5'h14, 8'h5A, 8'h50}};

   tiem_top i_dut (.hclk(hclk), .hresetn(hresetn), .standby(standby), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .flags(flags), .irq_req(irq_req));
   tiem_intc_model i_intc (.hclk(hclk), .hresetn(hresetn), .irq_req(irq_req), .clr(clr), .seen_r(seen));

   // Free-running system clock.
   always #5 hclk = ~hclk;

   // One single word transfer; every wait ends only on ready sampled high.
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
      haddr <= a;
      hwrite <= w;
      htrans <= TIEM_HTRANS_NONSEQ;
      hsel <= 1'b1;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
      resp_q = hresp;
   endtask

   // Compares a register read.
   task automatic chk32(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH t=%0t read %h expected %h", $time, g, e);
      end
   endtask

   // Compares a request vector.
   task automatic chkv(input logic [47:0] g, input logic [47:0] e);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH t=%0t requests %h expected %h", $time, g, e);
      end
   endtask

   // Single place where the run ends.
   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // Watchdog; the whole sequence needs well under a tenth of this span.
   initial begin
      #100000;
      bad_count++;
      tally_and_finish;
   end

   // Main sequence.
   initial begin
      logic [47:0] e;
      e = '0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int i = 0; i < 6; i++) begin
         xfer(1'b0, 32'(i * 4), '0, q);
         chk32(q, 32'h0);
      end
      // Table: write, read back, then flags on for three cycles, and off with exact latency.
      foreach (rows[k]) begin
         xfer(1'b1, {27'h0, rows[k].ofs}, {24'h0, rows[k].wr}, q);
         xfer(1'b0, {27'h0, rows[k].ofs}, '0, q);
         chk32(q, {24'h0, rows[k].rd});
         e[rows[k].ofs[4:2] * 8 +: 8] = rows[k].rd;
         if (k % 6 == 5) begin
            flags <= '1;
            repeat (3) @(posedge hclk);
            chkv(irq_req, e);
            flags <= '0;
            @(posedge hclk);
            chkv(irq_req, e);
            @(posedge hclk);
            chkv(irq_req, '0);
         end
      end
      // An address past the map must neither store nor alias onto the first register.
      xfer(1'b1, 32'h20, 32'hFF, q);
      xfer(1'b0, 32'h20, '0, q);
      chk32(q, 32'h0);
      chk32({31'h0, resp_q}, 32'h0);
      xfer(1'b0, 32'h0, '0, q);
      chk32(q, 32'h1A);
      // Channel 6 masked while 7 to 9 pass; capture flag A masked by a clear bit 0.
      xfer(1'b1, 32'h14, 32'h15, q);
      clr <= 1'b1;
      flags <= {8'h55, 32'h0, 8'h01};
      @(posedge hclk);
      clr <= 1'b0;
      repeat (4) @(posedge hclk);
      chkv(seen, {8'h15, 40'h0});
      xfer(1'b1, 32'h0, 32'h01, q);
      xfer(1'b1, 32'h14, 32'h55, q);
      repeat (2) @(posedge hclk);
      chkv(irq_req, {8'h55, 32'h0, 8'h01});
      xfer(1'b0, {27'h0, TIEM_OFS_REQLO}, '0, q);
      chk32(q, 32'h00000001);
      xfer(1'b1, 32'h0, 32'h00, q);
      repeat (2) @(posedge hclk);
      chkv(irq_req, {8'h55, 40'h0});
      // Channel-4 wrap passes while the channel-5 wrap flag stays low and channel 6 is idle.
      xfer(1'b1, 32'h10, 32'h84, q);
      flags <= {8'h15, 8'h80, 24'h0, 8'h01};
      repeat (2) @(posedge hclk);
      chkv(irq_req, {8'h15, 8'h80, 32'h0});
      xfer(1'b0, {27'h0, TIEM_OFS_REQHI}, '0, q);
      chk32(q, {16'h0, 8'h15, 8'h80});
      // Standby entry clears every enable.
      standby <= 1'b1;
      @(posedge hclk);
      standby <= 1'b0;
      repeat (2) @(posedge hclk);
      chkv(irq_req, '0);
      xfer(1'b0, 32'h10, '0, q);
      chk32(q, 32'h0);
      // A second reset in mid-run clears a freshly written enable.
      xfer(1'b1, 32'h4, 32'h7F, q);
      hresetn <= 1'b0;
      @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      xfer(1'b0, 32'h4, '0, q);
      chk32(q, 32'h0);
      flags <= '0;
      tally_and_finish;
   end
endmodule // tiem_top_test
